//--- hdl/lock_cmd_map.svh
// constants for the password lock command link: codes, field positions, counts
// assumes inclusion by bare name from the device and host modules
`ifndef LOCK_CMD_MAP_SVH
`define LOCK_CMD_MAP_SVH
`define CMD_SET_PASSWORD 8'hf1
`define CMD_UNLOCK 8'hf2
`define SECTOR_WORDS 9'h100
`define LAST_WORD 8'hff
`define PW_FIRST_WORD 8'h01
`define PW_LAST_WORD 8'h10
`define REV_WORD 8'h11
`define CTRL_SEL_BIT 0
`define CTRL_LEVEL_BIT 8
`define REV_NONE_LO 16'h0000
`define REV_NONE_HI 16'hffff
`define ATTEMPTS_INIT 3'h5
`define ERR_ABORT_BIT 2
`define ST_BUSY_BIT 7
`define ST_READY_BIT 6
`define ST_ERR_BIT 0
`define ST_IDLE 8'h40
`define ST_BUSY 8'h80
`define ADDR_CMD 2'h0
`define ADDR_CTRL 2'h1
`define ADDR_PW 2'h2
`define ADDR_STAT 2'h3
`endif

//--- hdl/lock_cmd_pkg.sv
// types shared by the two ends of the password lock command link
// assumes lock_cmd_map.svh is on the include path
`default_nettype none
package lock_cmd_pkg;
	typedef logic [15:0] word_t;
	typedef logic [255:0] password_t;
	typedef enum logic [1:0] {
		dev_idle = 2'b00,
		dev_recv = 2'b01,
		dev_exec = 2'b10
	} dev_state_t;
	typedef enum logic [1:0] {
		host_idle = 2'b00,
		host_cmd = 2'b01,
		host_data = 2'b10,
		host_wait = 2'b11
	} host_state_t;
endpackage
`default_nettype wire

//--- hdl/lock_cmd_if.sv
// link between a host controller and the password lock command handler
// assumes one shared clock; the host writes command, the device returns flags
`timescale 1ns/1ps
`default_nettype none
interface lock_cmd_if;
	logic [7:0] cmd_code;
	logic cmd_valid;
	logic [15:0] data_word;
	logic data_valid;
	logic data_ready;
	logic [7:0] command_error_flags;
	logic [7:0] command_status_flags;
	logic done;
	modport device (
		input cmd_code, cmd_valid, data_word, data_valid,
		output data_ready, command_error_flags, command_status_flags, done
	);
	modport host (
		output cmd_code, cmd_valid, data_word, data_valid,
		input data_ready, command_error_flags, command_status_flags, done
	);
endinterface
`default_nettype wire

//--- hdl/password_compare.sv
// 32-byte password equality, every byte significant
// assumes operands are stable in the cycle of use
`timescale 1ns/1ps
`default_nettype none
module password_compare
	import lock_cmd_pkg::*;
(
	input wire password_t given,
	input wire password_t stored,
	output logic equal
);
	assign equal = (given == stored);
endmodule
`default_nettype wire

//--- hdl/lock_device.sv
// device end: set-password and unlock command handler with lock state
// assumes host sends one command then exactly 256 words; power_on_b is
// the power-cycle reset, rst_b the hard reset
`timescale 1ns/1ps
`default_nettype none
`include "lock_cmd_map.svh"
module lock_device
	import lock_cmd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic power_on_b,
	input wire logic frozen,
	lock_cmd_if.device link,
	output logic locked,
	output logic lock_enabled,
	output logic max_level,
	output logic [15:0] identify_word92
);
	////////////////////////////////////////////////////////////////
	// persistent store: survives hard reset, cleared only at power-on
	typedef struct packed {
		password_t user_pw;
		password_t master_pw;
		word_t revision;
		logic enabled;
		logic level_max;
	} keep_t;
	// session state: hard reset reloads counter and relocks
	typedef struct packed {
		dev_state_t state;
		logic is_unlock;
		logic sel_master;
		logic level_bit;
		word_t rev_in;
		password_t pw_in;
		logic [7:0] word_idx;
		logic [2:0] attempts;
		logic unlocked;
		logic [7:0] err;
		logic [7:0] stat;
		logic done;
	} dev_reg_t;
	keep_t keep;
	keep_t next_keep;
	dev_reg_t r;
	dev_reg_t next_r;
	logic user_match;
	logic master_match;
	logic was_armed;

	password_compare user_cmp (
		.given(r.pw_in),
		.stored(keep.user_pw),
		.equal(user_match)
	);
	password_compare master_cmp (
		.given(r.pw_in),
		.stored(keep.master_pw),
		.equal(master_match)
	);

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_keep = keep;
		next_r = r;
		next_r.done = 1'b0;
		case (r.state)
			dev_idle:
			begin
				if (link.cmd_valid && (link.cmd_code == `CMD_SET_PASSWORD ||
					link.cmd_code == `CMD_UNLOCK))
				begin
					next_r.is_unlock = (link.cmd_code == `CMD_UNLOCK);
					next_r.word_idx = 8'h00;
					next_r.err = 8'h00;
					next_r.stat = `ST_BUSY;
					next_r.state = dev_recv;
				end
			end
			dev_recv:
			begin
				if (link.data_valid)
				begin
					if (r.word_idx == 8'h00)
					begin
						next_r.sel_master = link.data_word[`CTRL_SEL_BIT];
						next_r.level_bit = link.data_word[`CTRL_LEVEL_BIT];
					end
					else if (r.word_idx <= `PW_LAST_WORD)
						next_r.pw_in[(r.word_idx - `PW_FIRST_WORD) * 16 +: 16] =
							link.data_word;
					else if (r.word_idx == `REV_WORD)
						next_r.rev_in = link.data_word;
					next_r.word_idx = r.word_idx + 8'h01;
					// reserved words still consumed so the full sector drains
					if (r.word_idx == `LAST_WORD)
						next_r.state = dev_exec;
				end
			end
			dev_exec:
			begin
				// rejection checks sit after the sector so the host sees
				// a clean end; mismatch is the only compare abort
				next_r.stat = `ST_IDLE;
				if (frozen || r.attempts == 3'h0)
					next_r.err[`ERR_ABORT_BIT] = 1'b1;
				else if (!r.is_unlock)
				begin
					if (r.sel_master)
					begin
						next_keep.master_pw = r.pw_in;
						if (r.rev_in != `REV_NONE_LO &&
							r.rev_in != `REV_NONE_HI)
							next_keep.revision = r.rev_in;
					end
					else
					begin
						next_keep.user_pw = r.pw_in;
						next_keep.level_max = r.level_bit;
						next_keep.enabled = 1'b1;
					end
				end
				else if (!r.sel_master && !keep.enabled)
					next_r.err[`ERR_ABORT_BIT] = 1'b1;
				else if (r.sel_master && keep.level_max)
					next_r.err[`ERR_ABORT_BIT] = 1'b1;
				else if (r.sel_master ? master_match : user_match)
					next_r.unlocked = 1'b1;
				else
				begin
					next_r.err[`ERR_ABORT_BIT] = 1'b1;
					next_r.attempts = r.attempts - 3'h1;
				end
				if (next_r.err[`ERR_ABORT_BIT])
					next_r.stat[`ST_ERR_BIT] = 1'b1;
				next_r.done = 1'b1;
				next_r.state = dev_idle;
			end
			default:
				next_r.state = dev_idle;
		endcase
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge power_on_b)
	begin
		if (!power_on_b)
			keep <= '0;
		else
			keep <= next_keep;
	end

	// armed-at-reset snapshot: lock takes effect only on the next reset
	always_ff @(posedge core_clk or negedge power_on_b)
	begin
		if (!power_on_b)
			was_armed <= 1'b0;
		else if (!rst_b)
			was_armed <= keep.enabled;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			r <= '0;
			r.attempts <= `ATTEMPTS_INIT;
			// a hard reset drops any earlier unlock so an armed lock holds
			r.unlocked <= 1'b0;
			r.stat <= `ST_IDLE;
		end
		else
			r <= next_r;
	end

	// hold locked low during a hard reset and until the first edge after its release
	logic relock;
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			relock <= 1'b1;
		else
			relock <= 1'b0;
	end

	assign locked = keep.enabled && was_armed && !r.unlocked &&
		!relock;
	assign lock_enabled = keep.enabled;
	assign max_level = keep.level_max;
	assign identify_word92 = keep.revision;
	assign link.data_ready = (r.state == dev_recv);
	assign link.command_error_flags = r.err;
	assign link.command_status_flags = r.stat;
	assign link.done = r.done;
endmodule
`default_nettype wire

//--- hdl/lock_host.sv
// host end: issues one lock command and streams its 256-word sector
// assumes the device takes words whenever data_ready is high
`timescale 1ns/1ps
`default_nettype none
`include "lock_cmd_map.svh"
module lock_host
	import lock_cmd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	lock_cmd_if.host link
);
	typedef struct packed {
		host_state_t state;
		logic [7:0] code;
		word_t ctrl;
		word_t rev;
		password_t pw;
		logic [8:0] sent;
		logic [7:0] err;
		logic [7:0] stat;
		logic busy;
		word_t rdata;
	} host_reg_t;
	host_reg_t r;
	host_reg_t next_r;
	word_t cur_word;

	// word 0 control, 1..16 password, 17 revision, rest zero
	always_comb
	begin
		cur_word = 16'h0000;
		if (r.sent == 9'h000)
			cur_word = r.ctrl;
		else if (r.sent <= {1'b0, `PW_LAST_WORD})
			cur_word = r.pw[(r.sent[7:0] - `PW_FIRST_WORD) * 16 +: 16];
		else if (r.sent == {1'b0, `REV_WORD})
			cur_word = r.rev;
	end

	always_comb
	begin
		next_r = r;
		next_r.rdata = 16'h0000;
		if (wr)
		begin
			case (addr)
				// unknown codes never start a sector: the device would
				// not take it and the host would wait forever
				`ADDR_CMD:
					if (!r.busy && (wdata[7:0] == `CMD_SET_PASSWORD ||
						wdata[7:0] == `CMD_UNLOCK))
					begin
						next_r.code = wdata[7:0];
						next_r.busy = 1'b1;
						next_r.state = host_cmd;
					end
				`ADDR_CTRL: next_r.ctrl = wdata;
				`ADDR_PW: next_r.pw = {wdata, r.pw[255:16]};
				default: next_r.rev = wdata;
			endcase
		end
		if (rd)
			next_r.rdata = (addr == `ADDR_STAT) ?
				{r.err, r.stat} : {15'h0000, r.busy};
		case (r.state)
			host_idle: ;
			host_cmd:
			begin
				next_r.sent = 9'h000;
				next_r.state = host_data;
			end
			host_data:
				if (link.data_ready)
				begin
					next_r.sent = r.sent + 9'h001;
					if (r.sent == `SECTOR_WORDS - 9'h001)
						next_r.state = host_wait;
				end
			host_wait:
				if (link.done)
				begin
					// abort here came after the sector: a mismatch, frozen, no attempts left, or a barred password
					next_r.err = link.command_error_flags;
					next_r.stat = link.command_status_flags;
					next_r.busy = 1'b0;
					next_r.state = host_idle;
				end
			default: next_r.state = host_idle;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			r <= '0;
			// mirror the device's idle status until a command ends
			r.stat <= `ST_IDLE;
		end
		else
			r <= next_r;
	end

	assign rdata = r.rdata;
	assign link.cmd_code = r.code;
	assign link.cmd_valid = (r.state == host_cmd);
	assign link.data_word = cur_word;
	assign link.data_valid = (r.state == host_data);
endmodule
`default_nettype wire

//--- tb/lock_cmd_asserts.sv
// checker for the lock command link between host and device ends
// assumes the bench wires its inputs to the shared interface signals
`timescale 1ns/1ps
`default_nettype none
module lock_cmd_asserts (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_valid,
	input wire logic data_valid,
	input wire logic data_ready,
	input wire logic [7:0] command_error_flags,
	input wire logic [7:0] command_status_flags,
	input wire logic done
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_b);
//////////////////////////////////////////////////
logic take;
logic [8:0] words;
assign take = cmd_valid && !command_status_flags[7]
	&& (cmd_code == 8'hf1 || cmd_code == 8'hf2);
// counts words of the current sector only
always_ff @(posedge core_clk or negedge rst_b)
	if (!rst_b)
		words <= 9'h000;
	else if (take)
		words <= 9'h000;
	else if (data_valid && data_ready)
		words <= words + 9'h001;
//////////////////////////////////////////////////
property p_busy_on_take;
	take |=> command_status_flags == 8'h80;
endproperty
a_busy_on_take: assert property (p_busy_on_take) else $error("no busy");
property p_idle_at_done;
	done |-> command_status_flags[7:6] == 2'b01;
endproperty
a_idle_at_done: assert property (p_idle_at_done) else $error("busy");
property p_err_abort;
	done |-> command_status_flags[0] == command_error_flags[2];
endproperty
a_err_abort: assert property (p_err_abort) else $error("err");
property p_sector_len;
	done |-> words == 9'h100;
endproperty
a_sector_len: assert property (p_sector_len) else $error("length");
property p_ready_busy;
	data_ready |-> command_status_flags[7];
endproperty
a_ready_busy: assert property (p_ready_busy) else $error("ready");
property p_done_pulse;
	done |=> !done;
endproperty
a_done_pulse: assert property (p_done_pulse) else $error("pulse");
property p_done_bound;
	take |-> ##[256:600] done;
endproperty
a_done_bound: assert property (p_done_bound) else $error("no done");
// flags may change only at command start or with done
property p_flags_stand;
	!take ##1 !done |-> $stable({command_error_flags, command_status_flags});
endproperty
a_flags_stand: assert property (p_flags_stand) else $error("flags");
c_abort: cover property (done && command_error_flags[2]);
c_ok: cover property (done && !command_status_flags[0]);
c_unlock: cover property (take && cmd_code == 8'hf2);
endmodule
`default_nettype wire

//--- tb/drive_password_lock_commands_tb_top.sv
// bench: host and device ends joined by the link, driven via host registers
// assumes host offsets 0..3 and {error,status} read at offset 3
`timescale 1ns/1ps
`default_nettype none
module drive_password_lock_commands_tb_top;
logic core_clk = 1'b0;
logic rst_b = 1'b0;
logic power_on_b = 1'b0;
logic frozen = 1'b0;
logic [1:0] addr = 2'h0;
logic [15:0] wdata = 16'h0000;
logic wr = 1'b0;
logic rd = 1'b0;
logic [15:0] rdata;
logic locked;
logic lock_enabled;
logic max_level;
logic [15:0] word92;
logic [15:0] st;
logic [15:0] v;
int bad_count = 0;
int compares = 0;
assign st = {13'h0000, locked, lock_enabled, max_level};
initial
	forever #10 core_clk = ~core_clk;
//////////////////////////////////////////////////
lock_cmd_if lock_cmd_if_inst ();
lock_host lock_host_inst (.core_clk(core_clk), .rst_b(rst_b), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.link(lock_cmd_if_inst.host));
lock_device lock_device_inst (.core_clk(core_clk), .rst_b(rst_b),
	.power_on_b(power_on_b), .frozen(frozen),
	.link(lock_cmd_if_inst.device), .locked(locked),
	.lock_enabled(lock_enabled), .max_level(max_level),
	.identify_word92(word92));
lock_cmd_asserts lock_cmd_asserts_inst (.core_clk(core_clk), .rst_b(rst_b),
	.cmd_code(lock_cmd_if_inst.cmd_code),
	.cmd_valid(lock_cmd_if_inst.cmd_valid),
	.data_valid(lock_cmd_if_inst.data_valid),
	.data_ready(lock_cmd_if_inst.data_ready),
	.command_error_flags(lock_cmd_if_inst.command_error_flags),
	.command_status_flags(lock_cmd_if_inst.command_status_flags),
	.done(lock_cmd_if_inst.done));
//////////////////////////////////////////////////
task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
	compares++;
	if (s !== e)
	begin
		bad_count++;
		$display("BAD %s exp %h seen %h", n, e, s);
	end
endtask
task automatic summarize;
	$display("compares %0d bad_count %0d", compares, bad_count);
	if (bad_count == 0 && compares > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
	addr <= a;
	wdata <= d;
	wr <= 1'b1;
	@(posedge core_clk);
	wr <= 1'b0;
	@(posedge core_clk);
endtask
task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
	addr <= a;
	rd <= 1'b1;
	@(posedge core_clk);
	rd <= 1'b0;
	@(negedge core_clk);
	d = rdata;
	@(posedge core_clk);
endtask
task automatic hard_reset(input logic pwr);
	rst_b <= 1'b0;
	power_on_b <= !pwr;
	repeat (5) @(posedge core_clk);
	rst_b <= 1'b1;
	power_on_b <= 1'b1;
	// lock state settles one edge after release; look after that edge
	repeat (2) @(posedge core_clk);
endtask
// passwords share words 1-15 and differ only in the last word
task automatic run(input logic [7:0] code, input logic [15:0] ctrl,
	input logic [15:0] key, input logic [15:0] rev, input logic [15:0] e);
	int n;
	wr_reg(2'h1, ctrl);
	for (int i = 1; i <= 16; i++)
		wr_reg(2'h2, i == 16 ? key : {12'ha50, i[3:0]});
	wr_reg(2'h3, rev);
	wr_reg(2'h0, {8'h00, code});
	rd_reg(2'h0, v);
	chk("busy", v, 16'h0001);
	for (n = 0; n < 600 && lock_cmd_if_inst.done !== 1'b1; n++)
		@(negedge core_clk);
	if (n == 600)
	begin
		bad_count++;
		summarize();
	end
	@(posedge core_clk);
	rd_reg(2'h3, v);
	chk("flags", v, e);
	rd_reg(2'h0, v);
	chk("idle", v, 16'h0000);
endtask
//////////////////////////////////////////////////
initial
begin
	hard_reset(1'b1);
	rd_reg(2'h3, v);
	chk("reset", v, 16'h0040);
	wr_reg(2'h0, 16'h00e0);
	rd_reg(2'h0, v);
	chk("unknown", v, 16'h0000);
	run(8'hf2, 16'h0000, 16'h1111, 16'h0000, 16'h0441);
	run(8'hf1, 16'h0001, 16'h2222, 16'h1234, 16'h0040);
	chk("rev", word92, 16'h1234);
	run(8'hf1, 16'h0001, 16'h2222, 16'hffff, 16'h0040);
	run(8'hf1, 16'h0001, 16'h2222, 16'h0000, 16'h0040);
	chk("state", st, 16'h0000);
	run(8'hf1, 16'h0000, 16'h1111, 16'h5555, 16'h0040);
	chk("rev", word92, 16'h1234);
	chk("state", st, 16'h0002);
	hard_reset(1'b0);
	chk("state", st, 16'h0006);
	run(8'hf2, 16'h0000, 16'h1110, 16'h0000, 16'h0441);
	run(8'hf2, 16'h0001, 16'h2222, 16'h0000, 16'h0040);
	chk("state", st, 16'h0002);
	run(8'hf1, 16'h0100, 16'h3333, 16'h0000, 16'h0040);
	hard_reset(1'b0);
	chk("state", st, 16'h0007);
	run(8'hf2, 16'h0001, 16'h2222, 16'h0000, 16'h0441);
	run(8'hf2, 16'h0000, 16'h3333, 16'h0000, 16'h0040);
	hard_reset(1'b0);
	repeat (4) run(8'hf2, 16'h0000, 16'h3330, 16'h0000, 16'h0441);
	run(8'hf2, 16'h0000, 16'h3333, 16'h0000, 16'h0040);
	hard_reset(1'b0);
	repeat (5) run(8'hf2, 16'h0000, 16'h3330, 16'h0000, 16'h0441);
	run(8'hf2, 16'h0000, 16'h3333, 16'h0000, 16'h0441);
	chk("state", st, 16'h0007);
	hard_reset(1'b0);
	run(8'hf2, 16'h0000, 16'h3333, 16'h0000, 16'h0040);
	frozen <= 1'b1;
	run(8'hf1, 16'h0000, 16'h4444, 16'h0000, 16'h0441);
	frozen <= 1'b0;
	hard_reset(1'b1);
	chk("state", st, 16'h0000);
	summarize();
end
endmodule
`default_nettype wire
